//--- design/sfm_consts.svh
// Constants of the serial memory front end.
`ifndef SFM_CONSTS_SVH
`define SFM_CONSTS_SVH
`define SFM_ADDR_W        9
`define SFM_DEPTH         512
`define SFM_BYTE_W        8
`define SFM_BIT_CNT_W     3
`define SFM_LAST_BIT      3'h7
`define SFM_PIN_IDLE      4'hF
`define SFM_OP_LSET_CODE  8'h06
`define SFM_OP_LCLR_CODE  8'h04
`define SFM_OP_SRD_CODE   8'h05
`define SFM_OP_SWR_CODE   8'h01
`define SFM_OP_MEM_MASK   8'hF7
`define SFM_OP_READ_CODE  8'h03
`define SFM_OP_WRITE_CODE 8'h02
`define SFM_OP_ABIT       3
`define SFM_SR_WEL        1
`define SFM_SR_BP0        2
`define SFM_SR_BP1        3
`define SFM_SR_RESET      8'h00
`define SFM_SR_WMASK      8'h0C
`define SFM_MAX_SCK_MHZ   10
`endif

//--- design/sfm_pkg.sv
// Types of the serial memory front end.
package sfm_pkg;
   typedef enum logic [2:0] {
      SFM_OPCODE,
      SFM_ADDR,
      SFM_READ,
      SFM_WRITE,
      SFM_STAT_RD,
      SFM_STAT_WR,
      SFM_DONE,
      SFM_IGNORE
   } sfm_state_e;
endpackage

//--- design/sfm_spi_front_end.sv
// SPI slave front end of a 512-byte serial memory with status register.
`timescale 1ns/100ps
`include "sfm_consts.svh"
// How it works
// R1: 512 bytes, each reached by a unique 9-bit address.
// R2: Top address bit rides inside read and write opcodes.
// R3: One address byte follows with the low 8 bits.
// R4: Writes finish at bus speed; never busy.
// R5: Master keeps the serial clock at 10 MHz or below.
// R6: Input sampled on rising edges from first rise after select.
// R7: Output data changes on falling serial clock edges.
// R8: Clock low at select means mode 0, high means mode 3.
// R9: In mode 3 only rises after the first toggle count.
// R10: Master idles clock low in mode 0, high in mode 3.
// R11: First byte after select is the opcode.
// R12: One opcode per select; master deselects between operations.
// R13: Deselected: input ignored, output undriven.
// R14: All bytes travel most significant bit first.
// R15: Unknown opcode: do nothing, ignore input, keep output off.
// R16: An 8-bit status register configures the device.
// R17: Master waits the power-up delay before first select.
// R18: Device never starts a transfer itself.
// R19: Six opcodes decoded, memory ones carrying the top address bit.
// R20: Bit counter and command state reset while deselected.
module sfm_spi_front_end
#(
   parameter int ADDR_W = `SFM_ADDR_W,
   parameter int DEPTH  = `SFM_DEPTH
)
(
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic chip_sel_n_in,
   input  wire logic sck_in,
   input  wire logic si_in,
   input  wire logic write_prot_n_in,
   output logic      so_out,
   output logic      so_oe_out,
   output logic      sel_mode3_out,
   output logic      write_latch_out
);
   import sfm_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Pins come from another domain; each passes two flops first.
   logic [3:0] meta_reg;
   logic [3:0] sync_reg;
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         meta_reg <= `SFM_PIN_IDLE;
         sync_reg <= `SFM_PIN_IDLE;
      end
      else
      begin
         meta_reg <= {chip_sel_n_in, sck_in, si_in, write_prot_n_in};
         sync_reg <= meta_reg;
      end
   end
   logic cs_n_s;
   logic sck_s;
   logic si_s;
   logic wp_n_s;
   assign cs_n_s = sync_reg[3];
   assign sck_s  = sync_reg[2];
   assign si_s   = sync_reg[1];
   assign wp_n_s = sync_reg[0];

   logic cs_d_reg;
   logic sck_d_reg;
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         cs_d_reg  <= 1'b1;
         sck_d_reg <= 1'b0;
      end
      else
      begin
         cs_d_reg  <= cs_n_s;
         sck_d_reg <= sck_s;
      end
   end
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   assign cs_fall  = cs_d_reg & ~cs_n_s;
   assign cs_rise  = ~cs_d_reg & cs_n_s;
   assign sck_rise = ~sck_d_reg & sck_s & ~cs_n_s;   // R6
   assign sck_fall = sck_d_reg & ~sck_s & ~cs_n_s;   // R7

   // ----------------------------------------------------------------
   // Mode detection
   // ----------------------------------------------------------------
   // In mode 3 the clock first falls; counting rises only after it
   // keeps the idle-high level from being mistaken for a bit.
   logic armed_reg;
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sel_mode3_out <= 1'b0;
         armed_reg     <= 1'b0;
      end
      else if (cs_fall)
      begin
         sel_mode3_out <= sck_s;                     // R8
         armed_reg     <= ~sck_s;                    // R9
      end
      else if (sck_fall)
         armed_reg <= 1'b1;                          // R9
   end
   logic bit_take;
   assign bit_take = sck_rise & armed_reg & ~cs_fall;

   // ----------------------------------------------------------------
   // Shift and command sequencing
   // ----------------------------------------------------------------
   sfm_state_e                 state_reg;
   logic [`SFM_BIT_CNT_W-1:0]  bit_cnt_reg;
   logic [`SFM_BYTE_W-1:0]     shift_reg;
   logic [ADDR_W-1:0]          addr_reg;
   logic [`SFM_BYTE_W-1:0]     byte_in;
   logic                       byte_done;
   logic                       op_is_write_reg;
   assign byte_in   = {shift_reg[`SFM_BYTE_W-2:0], si_s};   // R14
   assign byte_done = bit_take && (bit_cnt_reg == `SFM_LAST_BIT);

   logic [`SFM_BYTE_W-1:0] mem [DEPTH];              // R1
   logic [`SFM_BYTE_W-1:0] status_reg;               // R16
   logic                   write_ok;
   logic                   wr_strobe;
   logic                   stat_wr_strobe;
   logic                   blk_prot;

   always_comb
   begin
      unique case (status_reg[`SFM_SR_BP1:`SFM_SR_BP0])
         2'h0: blk_prot = 1'b0;
         2'h1: blk_prot = addr_reg[ADDR_W-1] & addr_reg[ADDR_W-2];
         2'h2: blk_prot = addr_reg[ADDR_W-1];
         2'h3: blk_prot = 1'b1;
      endcase
   end
   assign write_ok    = write_latch_out & wp_n_s;
   assign wr_strobe   = byte_done && state_reg == SFM_WRITE && write_ok && !blk_prot;
   assign stat_wr_strobe = byte_done && state_reg == SFM_STAT_WR && write_ok;

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_reg   <= SFM_OPCODE;
         bit_cnt_reg <= '0;
         shift_reg   <= '0;
      end
      else if (cs_n_s || cs_fall)
      begin
         state_reg   <= SFM_OPCODE;                  // R20
         bit_cnt_reg <= '0;                          // R20
         shift_reg   <= '0;
      end
      else if (bit_take && state_reg != SFM_IGNORE)  // R15
      begin
         bit_cnt_reg <= bit_cnt_reg + 1'b1;
         shift_reg   <= byte_in;
         if (byte_done)
         begin
            unique case (state_reg)
               SFM_OPCODE:                           // R11 R19
               begin
                  if ((byte_in & `SFM_OP_MEM_MASK) == `SFM_OP_READ_CODE)
                     state_reg <= SFM_ADDR;
                  else if ((byte_in & `SFM_OP_MEM_MASK) == `SFM_OP_WRITE_CODE)
                     state_reg <= SFM_ADDR;
                  else if (byte_in == `SFM_OP_SRD_CODE)
                     state_reg <= SFM_STAT_RD;
                  else if (byte_in == `SFM_OP_SWR_CODE)
                     state_reg <= SFM_STAT_WR;
                  else if (byte_in == `SFM_OP_LSET_CODE || byte_in == `SFM_OP_LCLR_CODE)
                     state_reg <= SFM_DONE;
                  else
                     state_reg <= SFM_IGNORE;        // R15
               end
               SFM_ADDR:
                  state_reg <= op_is_write_reg ? SFM_WRITE : SFM_READ;
               SFM_STAT_RD: state_reg <= SFM_STAT_RD;
               SFM_STAT_WR: state_reg <= SFM_DONE;
               SFM_READ, SFM_WRITE, SFM_DONE, SFM_IGNORE:
                  state_reg <= state_reg;
            endcase
         end
      end
   end

   // The shift register has moved on to the address bits by the time
   // the address byte ends, so the opcode's write flag is held here.
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         op_is_write_reg <= 1'b0;
      else if (byte_done && state_reg == SFM_OPCODE)
         op_is_write_reg <= ((byte_in & `SFM_OP_MEM_MASK) == `SFM_OP_WRITE_CODE);
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         addr_reg <= '0;
      else if (byte_done && state_reg == SFM_OPCODE)
         addr_reg <= {byte_in[`SFM_OP_ABIT], {(ADDR_W-1){1'b0}}};   // R2
      else if (byte_done && state_reg == SFM_ADDR)
         addr_reg <= {addr_reg[ADDR_W-1], byte_in};                 // R3
      else if (byte_done && (state_reg == SFM_READ || state_reg == SFM_WRITE))
         addr_reg <= addr_reg + 1'b1;
   end

   // Each byte is stored the cycle it completes, so nothing is busy.
   always_ff @(posedge clk_in)
   begin
      if (wr_strobe)
         mem[addr_reg] <= byte_in;                   // R4
   end

   // ----------------------------------------------------------------
   // Status register and write latch
   // ----------------------------------------------------------------
   logic clr_pending_reg;
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         status_reg <= `SFM_SR_RESET;
      else if (stat_wr_strobe)
         status_reg <= byte_in & `SFM_SR_WMASK;      // R16
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         write_latch_out <= 1'b0;
         clr_pending_reg <= 1'b0;
      end
      else if (cs_fall)
         clr_pending_reg <= 1'b0;
      else if (byte_done && state_reg == SFM_OPCODE && byte_in == `SFM_OP_LSET_CODE)
         write_latch_out <= 1'b1;
      else if (byte_done && state_reg == SFM_OPCODE && byte_in == `SFM_OP_LCLR_CODE)
         clr_pending_reg <= 1'b1;
      else if (stat_wr_strobe || wr_strobe)
         clr_pending_reg <= 1'b1;
      else if (cs_rise && clr_pending_reg)
      begin
         write_latch_out <= 1'b0;
         clr_pending_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Serial output
   // ----------------------------------------------------------------
   // Output bytes load on the falling edge after the eighth rise.
   logic [`SFM_BYTE_W-1:0] out_sh_reg;
   logic                   load_pend_reg;
   logic                   reading;
   logic [`SFM_BYTE_W-1:0] stat_byte;
   assign reading   = (state_reg == SFM_READ) || (state_reg == SFM_STAT_RD);
   assign stat_byte = {status_reg[`SFM_BYTE_W-1:`SFM_SR_BP0], write_latch_out, 1'b0};
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         out_sh_reg    <= '0;
         load_pend_reg <= 1'b0;
         so_out        <= 1'b0;
         so_oe_out     <= 1'b0;
      end
      else if (cs_n_s)
      begin
         load_pend_reg <= 1'b0;
         so_oe_out     <= 1'b0;                      // R13
      end
      else
      begin
         if (byte_done)
            load_pend_reg <= 1'b1;
         if (sck_fall && load_pend_reg && reading)   // R7
         begin
            out_sh_reg    <= state_reg == SFM_STAT_RD ?
                             stat_byte : mem[addr_reg];
            so_out        <= state_reg == SFM_STAT_RD ?
                             stat_byte[`SFM_BYTE_W-1] : mem[addr_reg][`SFM_BYTE_W-1];
            so_oe_out     <= 1'b1;                   // R18
            load_pend_reg <= 1'b0;
         end
         else if (sck_fall && so_oe_out)
         begin
            out_sh_reg <= {out_sh_reg[`SFM_BYTE_W-2:0], 1'b0};
            so_out     <= out_sh_reg[`SFM_BYTE_W-2]; // R14
         end
         else if (sck_fall)
            load_pend_reg <= 1'b0;
         if (state_reg == SFM_IGNORE)
            so_oe_out <= 1'b0;                       // R15
      end
   end
endmodule // sfm_spi_front_end

//--- verif/sfm_master_model.sv
// SPI bus master model driving the serial memory front end.
`timescale 1ns/100ps
module sfm_master_model (
   input  wire logic clk_in,
   input  wire logic so_in,
   input  wire logic so_oe_in,
   output logic      cs_n_out,
   output logic      sck_out,
   output logic      si_out
);
   logic last = 1'h0;
   logic miso;
   initial cs_n_out = 1'h1;
   initial sck_out = 1'h0;
   initial si_out = 1'h0;
   always @(posedge clk_in) if (so_oe_in) last <= so_in;
   // A released line shows the inverse of its last bit, so a stale value cannot pass.
   assign miso = so_oe_in ? so_in : ~last;
   task automatic half();
      repeat (10) @(posedge clk_in);
      #1;
   endtask
   task automatic sel(input logic m3);
      sck_out = m3;
      half();
      cs_n_out = 1'h0;
      half();
   endtask
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         sck_out = 1'h0;
         si_out = tx[i];
         half();
         sck_out = 1'h1;
         rx[i] = miso;
         half();
      end
   endtask
   task automatic desel(input logic m3);
      sck_out = m3;
      half();
      cs_n_out = 1'h1;
      half();
      half();
   endtask
endmodule // sfm_master_model

//--- verif/sfm_chk.sv
// Pin checker of the serial memory front end.
`timescale 1ns/100ps
module sfm_chk (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic chip_sel_n_in,
   input wire logic sck_in,
   input wire logic so_out,
   input wire logic so_oe_out,
   input wire logic sel_mode3_out,
   input wire logic write_latch_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   oe_idle_a: assert property (chip_sel_n_in [*5] |-> !so_oe_out)
      else $error("so driven while idle");
   so_edge_a: assert property (so_oe_out && $changed(so_out) |-> !sck_in)
      else $error("so moved with sck high");
   mode3_sel_a: assert property ($fell(chip_sel_n_in) && sck_in |-> ##6 sel_mode3_out)
      else $error("mode 3 missed");
   mode0_sel_a: assert property ($fell(chip_sel_n_in) && !sck_in |-> ##6 !sel_mode3_out)
      else $error("mode 0 missed");
   no_start_a: assert property ($rose(so_oe_out) |-> !chip_sel_n_in && !sck_in)
      else $error("so enabled unasked");
   latch_clr_a: assert property ($fell(write_latch_out) |-> chip_sel_n_in)
      else $error("latch cleared in frame");
   latch_sel_a: assert property ($changed(write_latch_out) |-> !$past(chip_sel_n_in, 6))
      else $error("latch moved while idle");
   mode_hold_a: assert property (!chip_sel_n_in [*8] |-> $stable(sel_mode3_out))
      else $error("mode moved in frame");
   cover property ($rose(sel_mode3_out));
   cover property ($rose(so_oe_out) && sel_mode3_out);
   cover property ($fell(write_latch_out));
endmodule // sfm_chk
bind sfm_spi_front_end sfm_chk u_sfm_chk (.clk_in(clk_in), .rstn_in(rstn_in),
   .chip_sel_n_in(chip_sel_n_in), .sck_in(sck_in), .so_out(so_out), .so_oe_out(so_oe_out),
   .sel_mode3_out(sel_mode3_out), .write_latch_out(write_latch_out));

//--- verif/testbench.sv
// Self-checking bench of the serial memory front end.
`timescale 1ns/100ps
module testbench;
   logic       clk = 1'h0;
   logic       rstn = 1'h0;
   logic       cs_n, sck, si, so, oe, m3, wel;
   logic       oe_seen = 1'h0;
   logic [7:0] r;
   int         n_errors = 0;
   int         checks_done = 0;
   int         cyc = 0;
   always #4 clk = ~clk;
   sfm_spi_front_end u_sfm_spi_front_end (.clk_in(clk), .rstn_in(rstn), .chip_sel_n_in(cs_n),
      .sck_in(sck), .si_in(si), .write_prot_n_in(1'h1), .so_out(so), .so_oe_out(oe),
      .sel_mode3_out(m3), .write_latch_out(wel));
   sfm_master_model u_sfm_master_model (.clk_in(clk), .so_in(so), .so_oe_in(oe),
      .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (oe) oe_seen <= 1'h1;
      if (cyc == 40000) tally_and_finish(1'h1);
   end
   task automatic check(input string what, input logic [7:0] exp, got);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic md, input int n, input logic [7:0] b0,
                      input logic [7:0] b1 = 8'h00, input logic [7:0] b2 = 8'h00);
      u_sfm_master_model.sel(md);
      u_sfm_master_model.xbyte(b0, r);
      if (n > 1) u_sfm_master_model.xbyte(b1, r);
      if (n > 2) u_sfm_master_model.xbyte(b2, r);
      u_sfm_master_model.desel(md);
   endtask
   task automatic t_mode();
      cmd(1'h0, 2, 8'h05);
      check("status", 8'h00, r);
      check("mode0", 8'h00, {7'h00, m3});
      cmd(1'h1, 2, 8'h05);
      check("mode3", 8'h01, {7'h00, m3});
   endtask
   task automatic t_latch();
      cmd(1'h0, 1, 8'h06);
      check("wel set", 8'h01, {7'h00, wel});
      cmd(1'h1, 2, 8'h05);
      check("status", 8'h02, r);
      cmd(1'h0, 1, 8'h04);
      check("wel clr", 8'h00, {7'h00, wel});
   endtask
   task automatic t_status();
      cmd(1'h0, 1, 8'h06);
      cmd(1'h1, 2, 8'h01, 8'hFF);
      cmd(1'h0, 2, 8'h05);
      check("bp bits", 8'h0C, r);
      cmd(1'h0, 1, 8'h06);
      cmd(1'h0, 2, 8'h01, 8'h00);
      cmd(1'h1, 2, 8'h05);
      check("bp clr", 8'h00, r);
   endtask
   task automatic t_mem();
      cmd(1'h0, 1, 8'h06);
      cmd(1'h0, 3, 8'h0A, 8'h34, 8'hA5);
      check("wel wr", 8'h00, {7'h00, wel});
      cmd(1'h1, 1, 8'h06);
      cmd(1'h1, 3, 8'h02, 8'h34, 8'h5A);
      cmd(1'h0, 3, 8'h0B, 8'h34);
      check("hi byte", 8'hA5, r);
      cmd(1'h1, 3, 8'h03, 8'h34);
      check("lo byte", 8'h5A, r);
      cmd(1'h0, 1, 8'h06);
      cmd(1'h0, 2, 8'h01, 8'h08);
      cmd(1'h0, 1, 8'h06);
      cmd(1'h0, 3, 8'h02, 8'h34, 8'hC3);
      cmd(1'h0, 3, 8'h03, 8'h34);
      check("open half", 8'hC3, r);
      cmd(1'h0, 1, 8'h06);
      cmd(1'h0, 3, 8'h0A, 8'h34, 8'h00);
      cmd(1'h0, 3, 8'h0B, 8'h34);
      check("prot half", 8'hA5, r);
      cmd(1'h0, 1, 8'h06);
      cmd(1'h0, 2, 8'h01, 8'h00);
   endtask
   task automatic t_bad();
      oe_seen = 1'h0;
      cmd(1'h0, 3, 8'hFF, 8'h06, 8'h05);
      check("bad wel", 8'h00, {7'h00, wel});
      check("bad oe", 8'h00, {7'h00, oe_seen});
      cmd(1'h0, 2, 8'h05);
      check("after bad", 8'h00, r);
   endtask
   task automatic tally_and_finish(input bit hang);
      if (hang) n_errors++;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      #1 rstn = 1'h1;
      repeat (3) @(posedge clk);
      t_mode();
      t_latch();
      t_status();
      t_mem();
      t_bad();
      tally_and_finish(1'h0);
   end
endmodule // testbench
